// >>> include/qenc_pkg.sv
// shared constants for the dual quadrature encoder decoder
package qenc_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W = 24;
  localparam int ANG_W = 16;

  // ----------------------------------------------------------------
  // register indices; byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_POLE_PAIRS = 6'h1b;
  localparam logic [5:0] IDX_ENC1_CONFIG = 6'h25;
  localparam logic [5:0] IDX_ENC1_PPR = 6'h26;
  localparam logic [5:0] IDX_ENC1_COUNT = 6'h27;
  localparam logic [5:0] IDX_ENC1_INDEX = 6'h28;
  localparam logic [5:0] IDX_ENC1_OFFSETS = 6'h29;
  localparam logic [5:0] IDX_ENC1_ANGLES = 6'h2a;
  localparam logic [5:0] IDX_ENC2_CONFIG = 6'h2c;
  localparam logic [5:0] IDX_ENC2_PPR = 6'h2d;
  localparam logic [5:0] IDX_ENC2_COUNT = 6'h2e;
  localparam logic [5:0] IDX_ENC2_INDEX = 6'h2f;

  // ----------------------------------------------------------------
  // config register fields
  // ----------------------------------------------------------------
  localparam int A_POL_BIT = 0;
  localparam int B_POL_BIT = 1;
  localparam int N_POL_BIT = 2;
  localparam int INDEX_NEEDS_ALL_THREE_BIT = 3;
  localparam int XFER_DIR_BIT = 8;
  localparam int COUNT_DIR_BIT = 12;
  localparam logic [31:0] CONFIG_MASK = 32'h0000_110f;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
  localparam logic [23:0] PPR_RESET = 24'h00_1000;
  localparam logic [15:0] POLE_PAIRS_RESET = 16'h0001;
  localparam logic [15:0] OFFSET_RESET = 16'h0000;

endpackage : qenc_pkg

// >>> core/qenc_channel.sv
// one quadrature decoder channel: sync, edge decode, modulo counter, index latch
module qenc_channel (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic a_i,
  input wire logic b_i,
  input wire logic n_i,
  input wire logic [31:0] config_i,
  input wire logic [23:0] ppr_i,
  input wire logic count_wr_i,
  input wire logic index_wr_i,
  input wire logic [23:0] wdata_i,
  output logic [23:0] count_o,
  output logic [23:0] index_count_o,
  output logic index_event_o
);

  // ----------------------------------------------------------------
  // input synchronisers and history
  // ----------------------------------------------------------------
  logic [2:0] meta;
  logic [2:0] sync;
  logic a_d;
  logic b_d;
  logic nq_d;

  // two flops per pin; only the second stage is used downstream
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta <= 3'h0;
      sync <= 3'h0;
    end else begin
      meta <= {n_i, b_i, a_i};
      sync <= meta;
    end
  end

  // polarity applied after sync, so the first stage stays clean
  wire a_act = sync[0] ^ config_i[qenc_pkg::A_POL_BIT]; // R10
  wire b_act = sync[1] ^ config_i[qenc_pkg::B_POL_BIT]; // R10
  wire n_act = sync[2] ^ config_i[qenc_pkg::N_POL_BIT]; // R10
  // index alone, or index with both phases active
  wire n_qual = n_act & (~config_i[qenc_pkg::INDEX_NEEDS_ALL_THREE_BIT] | (a_act & b_act)); // R11

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      a_d <= 1'b0;
      b_d <= 1'b0;
      nq_d <= 1'b0;
    end else begin
      a_d <= a_act;
      b_d <= b_act;
      nq_d <= n_qual;
    end
  end

  // ----------------------------------------------------------------
  // quadrature decode and modulo stepping
  // ----------------------------------------------------------------
  // the history flops hold reset zeros, not pin levels, until the synchronisers have filled;
  // a pin parked high at reset release would otherwise look like an edge and move the count
  logic [1:0] warm;
  wire primed = (warm == 2'h3);
  wire [1:0] next_warm = primed ? warm : warm + 2'h1;

  // counts the edges after reset release, then rests
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      warm <= 2'h0;
    end else begin
      warm <= next_warm;
    end
  end

  // a double change xors to zero and is dropped as illegal
  wire step = primed & (a_act ^ a_d ^ b_act ^ b_d); // R15
  wire go_up = (a_act ^ b_d) ^ config_i[qenc_pkg::COUNT_DIR_BIT]; // R1
  wire [23:0] ppr_last = ppr_i - 24'h000001;
  // compare with >= so a shrunk ppr pulls the count back into range
  wire [23:0] cnt_inc = (count_o >= ppr_last) ? 24'h000000 : count_o + 24'h000001; // R3
  wire [23:0] cnt_dec = (count_o == 24'h000000 || count_o > ppr_last) ? ppr_last : count_o - 24'h000001; // R3
  wire idx_evt = primed & n_qual & ~nq_d;
  wire xfer_load = config_i[qenc_pkg::XFER_DIR_BIT];

  // software write wins over index action, which wins over a step
  wire [23:0] next_count = count_wr_i ? wdata_i : // R4
                           (idx_evt && xfer_load) ? index_count_o : // R6
                           step ? (go_up ? cnt_inc : cnt_dec) : count_o;
  wire [23:0] next_index = index_wr_i ? wdata_i :
                           (idx_evt && !xfer_load) ? count_o : index_count_o; // R5 R13

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      count_o <= 24'h000000;
      index_count_o <= 24'h000000;
    end else begin
      count_o <= next_count;
      index_count_o <= next_index;
    end
  end

  assign index_event_o = idx_evt;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  count_write_a: assert property (count_wr_i |=> count_o == $past(wdata_i)) // R4
    else $error("software count write not taken");
  wrap_up_a: assert property (step && go_up && !count_wr_i && !idx_evt && count_o == ppr_last |=> count_o == 24'h0) // R3
    else $error("count did not wrap to zero");
  step_up_a: assert property (step && go_up && !count_wr_i && !idx_evt && count_o < ppr_last
    |=> count_o == $past(count_o) + 24'h1) // R1
    else $error("count did not step by one");
  latch_a: assert property (idx_evt && !xfer_load && !index_wr_i |=> index_count_o == $past(count_o)) // R5
    else $error("index count not latched");
  reload_a: assert property (idx_evt && xfer_load && !count_wr_i |=> count_o == $past(index_count_o)) // R6
    else $error("count not reloaded at index");
  qualify_a: assert property (idx_evt && config_i[qenc_pkg::INDEX_NEEDS_ALL_THREE_BIT] |-> a_act && b_act) // R11
    else $error("index event without both phases");
  index_cov: cover property (idx_evt ##1 step);
  wrap_cov: cover property (step && !go_up && count_o == 24'h0);

endmodule : qenc_channel

// >>> core/qenc_dual_decoder.sv
// dual quadrature encoder decoder with register port and angle outputs
// Overview of operation
// R1 - direction bit flips counting sense
// R2 - per decoder 24-bit pulses per revolution
// R3 - 24-bit count wraps modulo ppr both ways
// R4 - count readable live, writable for initialisation
// R5 - index event latches decoder one count
// R6 - transfer bit picks latch or reload
// R7 - clearing index makes index count read zero
// R8 - mechanical angle from count, ppr, offset
// R9 - electrical angle from pole pairs, offset
// R10 - polarity bits invert a, b, index
// R11 - bit three requires a, b with index
// R12 - second decoder independent, never for commutation
// R13 - second decoder latches its own index count
// R14 - pole pair count is 16-bit unsigned
// R15 - synchronise inputs, count every quadrature edge
// R16 - encoder gives quadrature and one index
module qenc_dual_decoder (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic enc1_a_i,
  input wire logic enc1_b_i,
  input wire logic enc1_n_i,
  input wire logic enc2_a_i,
  input wire logic enc2_b_i,
  input wire logic enc2_n_i,
  output logic [15:0] enc1_phi_m_o,
  output logic [15:0] enc1_phi_e_o,
  output logic [23:0] enc2_count_o
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  wire aligned = (addr_i[1:0] == 2'b00);
  wire [5:0] reg_idx = addr_i[7:2];
  wire hit_pp = aligned && reg_idx == qenc_pkg::IDX_POLE_PAIRS;
  wire hit_cfg1 = aligned && reg_idx == qenc_pkg::IDX_ENC1_CONFIG;
  wire hit_ppr1 = aligned && reg_idx == qenc_pkg::IDX_ENC1_PPR;
  wire hit_cnt1 = aligned && reg_idx == qenc_pkg::IDX_ENC1_COUNT;
  wire hit_idx1 = aligned && reg_idx == qenc_pkg::IDX_ENC1_INDEX;
  wire hit_off1 = aligned && reg_idx == qenc_pkg::IDX_ENC1_OFFSETS;
  wire hit_ang1 = aligned && reg_idx == qenc_pkg::IDX_ENC1_ANGLES;
  wire hit_cfg2 = aligned && reg_idx == qenc_pkg::IDX_ENC2_CONFIG;
  wire hit_ppr2 = aligned && reg_idx == qenc_pkg::IDX_ENC2_PPR;
  wire hit_cnt2 = aligned && reg_idx == qenc_pkg::IDX_ENC2_COUNT;
  wire hit_idx2 = aligned && reg_idx == qenc_pkg::IDX_ENC2_INDEX;

  // ----------------------------------------------------------------
  // software settings
  // ----------------------------------------------------------------
  logic [15:0] pole_pairs;
  logic [31:0] enc1_config;
  logic [23:0] enc1_pulses_per_rev;
  logic [15:0] phi_m_offset;
  logic [15:0] phi_e_offset;
  logic [31:0] enc2_config;
  logic [23:0] enc2_pulses_per_rev;

  // plain settings; undefined config bits are dropped by the mask
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pole_pairs <= qenc_pkg::POLE_PAIRS_RESET;
      enc1_config <= qenc_pkg::CONFIG_RESET;
      enc1_pulses_per_rev <= qenc_pkg::PPR_RESET;
      phi_m_offset <= qenc_pkg::OFFSET_RESET;
      phi_e_offset <= qenc_pkg::OFFSET_RESET;
      enc2_config <= qenc_pkg::CONFIG_RESET;
      enc2_pulses_per_rev <= qenc_pkg::PPR_RESET;
    end else if (wr_i) begin
      if (hit_pp) pole_pairs <= wdata_i[15:0]; // R14
      if (hit_cfg1) enc1_config <= wdata_i & qenc_pkg::CONFIG_MASK;
      if (hit_ppr1) enc1_pulses_per_rev <= wdata_i[23:0]; // R2
      if (hit_off1) begin
        phi_m_offset <= wdata_i[15:0];
        phi_e_offset <= wdata_i[31:16];
      end
      if (hit_cfg2) enc2_config <= wdata_i & qenc_pkg::CONFIG_MASK; // R12
      if (hit_ppr2) enc2_pulses_per_rev <= wdata_i[23:0]; // R2
    end
  end

  // ----------------------------------------------------------------
  // the two decoder channels
  // ----------------------------------------------------------------
  logic [23:0] enc1_step_count;
  logic [23:0] enc1_index_count;
  logic [23:0] enc2_step_count;
  logic [23:0] enc2_index_count;
  logic enc1_event;
  logic enc2_event;

  // clearing at index: program index count to zero and set the transfer bit
  qenc_channel u_enc1 (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .a_i(enc1_a_i),
    .b_i(enc1_b_i),
    .n_i(enc1_n_i),
    .config_i(enc1_config),
    .ppr_i(enc1_pulses_per_rev),
    .count_wr_i(wr_i && hit_cnt1),
    .index_wr_i(wr_i && hit_idx1),
    .wdata_i(wdata_i[23:0]),
    .count_o(enc1_step_count),
    .index_count_o(enc1_index_count),
    .index_event_o(enc1_event)
  );

  // second channel feeds no angle path, only its count leaves the block on a port of its own
  qenc_channel u_enc2 (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .a_i(enc2_a_i),
    .b_i(enc2_b_i),
    .n_i(enc2_n_i),
    .config_i(enc2_config),
    .ppr_i(enc2_pulses_per_rev),
    .count_wr_i(wr_i && hit_cnt2),
    .index_wr_i(wr_i && hit_idx2),
    .wdata_i(wdata_i[23:0]),
    .count_o(enc2_step_count),
    .index_count_o(enc2_index_count),
    .index_event_o(enc2_event)
  );

  assign enc2_count_o = enc2_step_count; // R12

  // ----------------------------------------------------------------
  // angle computation
  // ----------------------------------------------------------------
  // a full divider in one cycle; costly in area but exact and latency of one
  wire [39:0] scaled_count = {enc1_step_count, 16'h0000};
  wire [39:0] ppr_ext = {16'h0000, enc1_pulses_per_rev};
  wire [39:0] quotient = (enc1_pulses_per_rev == 24'h000000) ? 40'h0 : scaled_count / ppr_ext;
  wire [15:0] next_phi_m = quotient[15:0] + phi_m_offset; // R8
  wire [31:0] phi_product = next_phi_m * pole_pairs;
  wire [15:0] next_phi_e = phi_product[15:0] + phi_e_offset; // R9

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      enc1_phi_m_o <= 16'h0000;
      enc1_phi_e_o <= 16'h0000;
    end else begin
      enc1_phi_m_o <= next_phi_m;
      enc1_phi_e_o <= next_phi_e;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // unmapped or misaligned addresses read zero
  wire [31:0] read_sel =
    hit_pp ? {16'h0000, pole_pairs} :
    hit_cfg1 ? enc1_config :
    hit_ppr1 ? {8'h00, enc1_pulses_per_rev} :
    hit_cnt1 ? {8'h00, enc1_step_count} : // R4
    hit_idx1 ? {8'h00, enc1_index_count} : // R5 R7
    hit_off1 ? {phi_e_offset, phi_m_offset} :
    hit_ang1 ? {enc1_phi_e_o, enc1_phi_m_o} : // R9
    hit_cfg2 ? enc2_config :
    hit_ppr2 ? {8'h00, enc2_pulses_per_rev} :
    hit_cnt2 ? {8'h00, enc2_step_count} :
    hit_idx2 ? {8'h00, enc2_index_count} : 32'h0000_0000; // R13

  // data stand for one cycle after the strobe, zero otherwise
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= 32'h0000_0000;
    end else begin
      rdata_o <= rd_i ? read_sel : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  read_count_a: assert property (rd_i && hit_cnt1 |=> rdata_o == {8'h00, $past(enc1_step_count)}) // R4
    else $error("count read mismatch");
  zero_angle_a: assert property (enc1_step_count == 24'h0 && wr_i == 1'b0
    |=> enc1_phi_m_o == $past(phi_m_offset)) // R8
    else $error("mechanical angle not equal offset at zero count");
  elec_unity_a: assert property (pole_pairs == 16'h0001 && phi_e_offset == 16'h0000
    |=> enc1_phi_e_o == enc1_phi_m_o) // R9
    else $error("electrical angle differs at one pole pair");
  clear_index_a: assert property (enc1_event && enc1_config[qenc_pkg::XFER_DIR_BIT] && enc1_index_count == 24'h0
    && !wr_i |=> enc1_step_count == 24'h0 && enc1_index_count == 24'h0) // R7
    else $error("index clear did not zero count");
  enc2_latch_a: assert property (enc2_event && !enc2_config[qenc_pkg::XFER_DIR_BIT] && !wr_i
    |=> enc2_index_count == $past(enc2_step_count)) // R13
    else $error("second decoder index latch missed");
  read_idle_a: assert property (!rd_i |=> rdata_o == 32'h0) // R4
    else $error("read data outside the answer cycle");

  // ----------------------------------------------------------------
  // register port checks
  // ----------------------------------------------------------------
  // every setting write lands at the edge that samples the strobe
  pole_write_a: assert property (wr_i && hit_pp |=> pole_pairs == $past(wdata_i[15:0])) // R14
    else $error("pole pair write not taken");
  ppr1_write_a: assert property (wr_i && hit_ppr1 |=> enc1_pulses_per_rev == $past(wdata_i[23:0])) // R2
    else $error("first decoder ppr write not taken");
  ppr2_write_a: assert property (wr_i && hit_ppr2 |=> enc2_pulses_per_rev == $past(wdata_i[23:0])) // R2 R12
    else $error("second decoder ppr write not taken");
  offset_write_a: assert property (wr_i && hit_off1 |=> {phi_e_offset, phi_m_offset} == $past(wdata_i)) // R8 R9
    else $error("angle offset write not taken");
  count2_write_a: assert property (wr_i && hit_cnt2 |=> enc2_count_o == $past(wdata_i[23:0])) // R4 R12
    else $error("second decoder count write not taken");

  // answers carry the value that stood at the strobe, upper bits zero for the index counts
  read_index_a: assert property (rd_i && hit_idx1 |=> rdata_o == {8'h00, $past(enc1_index_count)}) // R5
    else $error("index count read mismatch");
  read_index2_a: assert property (rd_i && hit_idx2 |=> rdata_o == {8'h00, $past(enc2_index_count)}) // R13
    else $error("second index count read mismatch");
  read_angle_a: assert property (rd_i && hit_ang1 |=> rdata_o == {$past(enc1_phi_e_o), $past(enc1_phi_m_o)}) // R9
    else $error("angle read mismatch");

  // misaligned addresses never reach a register, so software sees zero
  misaligned_a: assert property (rd_i && !aligned |=> rdata_o == 32'h0) // R4
    else $error("misaligned read returned data");

  read_cov: cover property (rd_i && hit_ang1 ##1 rdata_o != 32'h0);
  enc2_event_cov: cover property (enc2_event);
  both_event_cov: cover property (enc1_event && enc2_event);

endmodule : qenc_dual_decoder

// >>> bench/qenc_encoder_model.sv
// behavioural incremental encoder with index, moved one quadrature step at a time
module qenc_encoder_model (
  input wire logic mclk_i,
  input wire logic step_i,
  input wire logic dir_i,
  input wire logic index_i,
  output logic a_o,
  output logic b_o,
  output logic n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] phase = 2'h0;
  // gray walk: exactly one of a or b moves per step, so the pair stays a quarter period apart
  always @(posedge mclk_i) begin
    if (step_i) begin
      phase <= dir_i ? phase - 2'h1 : phase + 2'h1;
    end
  end
  // forward walk has a leading a
  assign a_o = phase[1] ^ phase[0];
  assign b_o = phase[1];
  // index placed by the bench, passed straight through whatever the phase
  assign n_o = index_i;
endmodule : qenc_encoder_model

// >>> bench/incremental_encoder_decoder_tb.sv
// self-checking bench for the dual quadrature decoder and two encoder models
module incremental_encoder_decoder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // stimulus and observation
  // ----
  typedef struct packed {
    logic [31:0] cfg;
    logic [23:0] ppr;
    logic [23:0] start;
    logic [3:0] steps;
    logic dir;
    logic [23:0] cnt;
  } row_type;
  localparam logic [7:0] PP = 8'h6c, CF1 = 8'h94, PR1 = 8'h98, CN1 = 8'h9c, IX1 = 8'ha0, OF1 = 8'ha4;
  localparam logic [7:0] AN1 = 8'ha8, CF2 = 8'hb0, PR2 = 8'hb4, CN2 = 8'hb8, IX2 = 8'hbc;
  logic mclk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [1:0] step_i = 2'h0;
  logic [1:0] dir_i = 2'h0;
  logic [1:0] index_i = 2'h0;
  wire [1:0] a;
  wire [1:0] b;
  wire [1:0] n;
  logic [31:0] rdata_o;
  logic [15:0] enc1_phi_m_o;
  logic [15:0] enc1_phi_e_o;
  logic [23:0] enc2_count_o;
  int miscompares = 0;
  int n_tests = 0;
  row_type rows [7];
  qenc_dual_decoder qenc_dual_decoder_inst (.mclk_i(mclk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .enc1_a_i(a[0]), .enc1_b_i(b[0]), .enc1_n_i(n[0]),
    .enc2_a_i(a[1]), .enc2_b_i(b[1]), .enc2_n_i(n[1]), .enc1_phi_m_o(enc1_phi_m_o),
    .enc1_phi_e_o(enc1_phi_e_o), .enc2_count_o(enc2_count_o));
  qenc_encoder_model enc1_model (.mclk_i(mclk_i), .step_i(step_i[0]), .dir_i(dir_i[0]), .index_i(index_i[0]),
    .a_o(a[0]), .b_o(b[0]), .n_o(n[0]));
  qenc_encoder_model enc2_model (.mclk_i(mclk_i), .step_i(step_i[1]), .dir_i(dir_i[1]), .index_i(index_i[1]),
    .a_o(a[1]), .b_o(b[1]), .n_o(n[1]));
  // free-running 200 MHz system clock
  always #2.5 mclk_i = ~mclk_i;
  // ----
  // bus and pin tasks
  // ----
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge mclk_i);
    addr_i <= ad;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask : wr
  // a settings change may look like a pin edge; let it settle before anything else
  task automatic cfg(input logic [7:0] ad, input logic [31:0] d);
    wr(ad, d);
    repeat (6) @(posedge mclk_i);
  endtask : cfg
  // read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd(input logic [7:0] ad, input logic [31:0] exp);
    @(posedge mclk_i);
    addr_i <= ad;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    check($sformatf("reg %h", ad), rdata_o, exp);
  endtask : rd
  // steps spaced six cycles, well below one phase change per clock
  task automatic step(input int sel, input logic dir, input int cnt);
    repeat (cnt) begin
      @(posedge mclk_i);
      step_i[sel] <= 1'b1;
      dir_i[sel] <= dir;
      @(posedge mclk_i);
      step_i[sel] <= 1'b0;
      repeat (4) @(posedge mclk_i);
    end
  endtask : step
  task automatic pulse(input int sel);
    @(posedge mclk_i);
    index_i[sel] <= 1'b1;
    repeat (3) @(posedge mclk_i);
    index_i[sel] <= 1'b0;
    repeat (5) @(posedge mclk_i);
  endtask : pulse
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report
  // ----
  // main sequence
  // ----
  initial begin
    rows[0] = '{32'h0, 24'h64, 24'h5, 4'h3, 1'b0, 24'h8};
    rows[1] = '{32'h1000, 24'h64, 24'h5, 4'h3, 1'b0, 24'h2};
    rows[2] = '{32'h0, 24'h64, 24'h62, 4'h3, 1'b0, 24'h1};
    rows[3] = '{32'h0, 24'h64, 24'h1, 4'h3, 1'b1, 24'h62};
    rows[4] = '{32'h1, 24'h64, 24'ha, 4'h2, 1'b0, 24'h8};
    rows[5] = '{32'h2, 24'h64, 24'ha, 4'h2, 1'b0, 24'h8};
    rows[6] = '{32'h1003, 24'h64, 24'ha, 4'h2, 1'b0, 24'h8};
    repeat (12) @(posedge mclk_i);
    nrst_i <= 1'b1;
    rd(PP, 32'h1);
    rd(PR1, 32'h1000);
    rd(CN1, 32'h0);
    rd(IX1, 32'h0);
    rd(OF1, 32'h0);
    rd(AN1, 32'h0);
    rd(CF2, 32'h0);
    rd(PR2, 32'h1000);
    rd(8'h04, 32'h0);
    rd(8'h99, 32'h0);
    @(posedge mclk_i);
    #1;
    check("rdata idle", rdata_o, 32'h0);
    // counting cases: polarity, direction and both wrap points
    foreach (rows[i]) begin
      cfg(CF1, rows[i].cfg);
      wr(PR1, {8'hff, rows[i].ppr});
      wr(CN1, {8'h0, rows[i].start});
      step(0, rows[i].dir, rows[i].steps);
      rd(PR1, {8'h0, rows[i].ppr});
      rd(CN1, {8'h0, rows[i].cnt});
    end
    // angles from count 0x400 of 0x1000 with three pole pairs; angle writes are dropped
    cfg(CF1, 32'h0);
    wr(PR1, 32'h1000);
    wr(PP, 32'h3);
    wr(OF1, 32'h0010_0100);
    wr(CN1, 32'h400);
    wr(AN1, 32'hffff_ffff);
    repeat (3) @(posedge mclk_i);
    #1;
    check("phi_m", enc1_phi_m_o, 32'h4100);
    check("phi_e", enc1_phi_e_o, 32'hc310);
    rd(AN1, 32'hc310_4100);
    // index latch, reload, then reload of zero
    wr(CN1, 32'h20);
    pulse(0);
    rd(IX1, 32'h20);
    wr(IX1, 32'h7);
    cfg(CF1, 32'h100);
    wr(CN1, 32'h30);
    pulse(0);
    rd(CN1, 32'h7);
    wr(IX1, 32'h0);
    pulse(0);
    rd(CN1, 32'h0);
    rd(IX1, 32'h0);
    // inverted index: only the release of the pin is an event
    cfg(CF1, 32'h4);
    wr(CN1, 32'h33);
    wr(IX1, 32'h0);
    @(posedge mclk_i);
    index_i[0] <= 1'b1;
    repeat (6) @(posedge mclk_i);
    rd(IX1, 32'h0);
    wr(CN1, 32'h44);
    @(posedge mclk_i);
    index_i[0] <= 1'b0;
    repeat (6) @(posedge mclk_i);
    rd(IX1, 32'h44);
    // qualified index ignored unless a and b are both high
    cfg(CF1, 32'h8);
    wr(IX1, 32'h0);
    for (int k = 0; k < 4 && a[0] && b[0]; k++) step(0, 1'b0, 1);
    check("a and b both high", {31'h0, a[0] & b[0]}, 32'h0);
    pulse(0);
    rd(IX1, 32'h0);
    for (int k = 0; k < 4 && !(a[0] && b[0]); k++) step(0, 1'b0, 1);
    check("a and b both high", {31'h0, a[0] & b[0]}, 32'h1);
    wr(CN1, 32'h11);
    pulse(0);
    rd(IX1, 32'h11);
    // second decoder runs on its own settings and leaves the first alone
    cfg(CF2, 32'h1000);
    wr(PR2, 32'h32);
    wr(CN2, 32'h0);
    step(1, 1'b0, 2);
    check("enc2 count", enc2_count_o, 32'h30);
    rd(CN2, 32'h30);
    rd(CN1, 32'h11);
    pulse(1);
    rd(IX2, 32'h30);
    wr(IX2, 32'h0);
    cfg(CF2, 32'h1100);
    pulse(1);
    rd(CN2, 32'h0);
    rd(IX2, 32'h0);
    // reset in mid-run with the first encoder parked on one high phase: no false step after release
    step(0, 1'b0, 1);
    @(posedge mclk_i);
    nrst_i <= 1'b0;
    @(posedge mclk_i);
    #1;
    check("phi_m in reset", enc1_phi_m_o, 32'h0);
    check("enc2 count in reset", enc2_count_o, 32'h0);
    repeat (11) @(posedge mclk_i);
    nrst_i <= 1'b1;
    repeat (6) @(posedge mclk_i);
    rd(PP, 32'h1);
    rd(CF1, 32'h0);
    rd(CN1, 32'h0);
    rd(IX2, 32'h0);
    rd(AN1, 32'h0);
    final_report();
  end
endmodule : incremental_encoder_decoder_tb
